// ### pkg/vtm_pkg.sv
// Shared constants and types of the tributary to container mapper.
// Assumes one core clock domain plus the tributary bit clock domain.
package vtm_pkg;

	typedef enum logic {VTM_BYTE_SYNC, VTM_ASYNC} vtm_variant_type;
	typedef enum logic {VTM_HUNT, VTM_RUN} vtm_state_type;
	typedef enum logic [1:0] {VTM_JUST_NONE, VTM_JUST_POS, VTM_JUST_NEG} vtm_just_type;

	// Container frame: four blocks of 35 byte slots, 140 slots per frame
	localparam logic [1:0] BLK_LAST = 2'h3;
	localparam logic [5:0] OFF_POH = 6'h00;
	localparam logic [5:0] OFF_CTRL = 6'h01;
	localparam logic [5:0] OFF_TS_FIRST = 6'h02;
	localparam logic [5:0] OFF_TS_LAST = 6'h21;
	localparam logic [5:0] OFF_LAST = 6'h22;

	// Payload type labels, placed in bits 1 to 3 of the path label byte
	localparam logic [2:0] LBL_BYTE_SYNC = 3'h4;
	localparam logic [2:0] LBL_ASYNC = 3'h2;
	localparam int LBL_LSB = 1;

	// Clock multiplier 35/32 as byte credits
	localparam logic [7:0] MUL_NUM = 8'h23;
	localparam logic [7:0] MUL_DEN = 8'h20;

	// Store depth as address width; bit reservoir for the async reader
	localparam int STORE_AW = 5;
	localparam int RES_W = 16;
	localparam logic [4:0] RES_FULL = 5'h10;
	localparam logic [6:0] LVL_LOW = 7'h10;
	localparam logic [6:0] LVL_HIGH = 7'h20;
	// Words held, start word included, before the byte-sync reader locks
	localparam logic [STORE_AW:0] LOCK_FILL = 6'h08;

	localparam logic [7:0] BYTE_ONES = 8'hff;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

endpackage : vtm_pkg

// ### tb/tb_vtm_mapper.sv
// Self-checking bench for the byte-synchronous mapper.
// Assumes the tributary model and checker are compiled before it.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_vtm_mapper import vtm_pkg::*;;
	logic core_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic fail = 1'b0;
	logic mgmt = 1'b0;
	logic t_data;
	logic t_fs;
	logic [7:0] dout;
	logic stb;
	logic fs_out;
	logic oe;
	int num_errors = 0;
	int compares = 0;
	// Core clock
	always #4 core_clk = ~core_clk;
	// Tributary clock with offset phase
	initial begin
		#1.3;
		forever #3 link_clk = ~link_clk;
	end
	vtm_trib_src u_vtm_trib_src (.clk(link_clk), .rst(rst), .data(t_data), .fs(t_fs));
	vtm_mapper #(.VARIANT(VTM_BYTE_SYNC)) u_vtm_mapper (
		.core_clk(core_clk), .rst(rst), .tributary_clock_in(link_clk), .tributary_data_in(t_data),
		.tributary_frame_start_in(t_fs), .upstream_signal_fail_in(fail), .mgmt_activate(mgmt),
		.timing_clock_in(1'b0), .timing_frame_start_in(1'b0), .container_data_out(dout),
		.container_clock_out(stb), .container_frame_start_out(fs_out), .container_output_enable(oe));
	// Verdict and end of run
	task final_report;
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report
	// Wait for the next byte strobe
	task automatic next_stb(output logic [7:0] d, output logic f);
		int n;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (stb !== 1'b1 && n < 64);
		`CHK(stb, 1'b1)
		d = dout;
		f = fs_out;
	endtask : next_stb
	// Walk block 0 of one frame from the label byte
	task automatic t_frame(input logic ones);
		logic [7:0] d;
		logic f;
		int n;
		n = 0;
		do begin
			next_stb(d, f);
			n++;
		end while (f !== 1'b1 && n < 300);
		`CHK(f, 1'b1)
		`CHK(d, {4'h0, LBL_BYTE_SYNC, 1'b0})
		next_stb(d, f);
		`CHK(d, 8'h00)
		for (int s = 0; s < 32; s++) begin
			next_stb(d, f);
			`CHK(d, ones ? BYTE_ONES : {3'h5, 5'(s)})
		end
		next_stb(d, f);
		`CHK(d, 8'h00)
	endtask : t_frame
	// Upstream fail gives all-ones slots, then normal data again
	task automatic t_fail;
		@(posedge core_clk);
		fail <= 1'b1;
		repeat (20) @(posedge core_clk);
		t_frame(1'b1);
		@(posedge core_clk);
		fail <= 1'b0;
		repeat (400) @(posedge core_clk);
		t_frame(1'b0);
	endtask : t_fail
	// Inactive mapper stays off the access point
	task automatic t_inactive;
		@(posedge core_clk);
		mgmt <= 1'b0;
		repeat (3) @(negedge core_clk);
		repeat (250) begin
			@(negedge core_clk);
			`CHK({stb, fs_out, oe, dout}, 11'h000)
		end
		@(posedge core_clk);
		mgmt <= 1'b1;
		repeat (2) @(negedge core_clk);
		`CHK(oe, 1'b1)
		repeat (400) @(posedge core_clk);
		t_frame(1'b0);
	endtask : t_inactive
	// Main sequence
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		mgmt <= 1'b1;
		repeat (1400) @(posedge core_clk);
		t_frame(1'b0);
		t_fail;
		t_inactive;
		repeat (1500) @(posedge core_clk);
		final_report;
	end
	// Watchdog against a hang
	initial begin
		#200000;
		num_errors++;
		final_report;
	end
endmodule : tb_vtm_mapper

// ### tb/vtm_mapper_props.sv
// Container side checker for the mapper, bound into every mapper instance.
// Assumes one core clock domain and a steady tributary stream once locked.
`timescale 1ns/1ps
module vtm_mapper_props import vtm_pkg::*; #(
	parameter vtm_variant_type VARIANT = VTM_BYTE_SYNC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic upstream_signal_fail_in,
	input wire logic mgmt_activate,
	input wire logic [7:0] container_data_out,
	input wire logic container_clock_out,
	input wire logic container_frame_start_out,
	input wire logic container_output_enable
);
	localparam logic [2:0] LBL = (VARIANT == VTM_BYTE_SYNC) ? LBL_BYTE_SYNC : LBL_ASYNC;
	logic ok_ff;
	logic [9:0] calm_ff;
	logic [7:0] slot_ff;
	logic [9:0] cyc_ff;
	wire logic stb = container_clock_out;
	wire logic fs = container_frame_start_out;
	wire logic [7:0] idx = slot_ff + 8'h01;
	wire logic [7:0] pos = idx % 8'h23;
	// Counts since the last frame start, trusted only after a calm spell
	always_ff @(posedge core_clk) begin
		calm_ff <= (rst || upstream_signal_fail_in || !mgmt_activate) ? 10'h000 : calm_ff + {9'h000, calm_ff != 10'h3ff};
		ok_ff <= (calm_ff != 10'h3ff) ? 1'b0 : (fs | ok_ff);
		slot_ff <= fs ? 8'h00 : slot_ff + {7'h00, stb};
		cyc_ff <= fs ? 10'h000 : cyc_ff + {9'h000, cyc_ff != 10'h3ff};
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence idle_two;
		!mgmt_activate ##1 !mgmt_activate;
	endsequence
	label_byte_a: assert property (fs |-> stb && container_data_out == {4'h0, LBL, 1'b0})
		else $error("label byte wrong at frame start");
	frame_len_a: assert property (fs && ok_ff |-> slot_ff == 8'h8b)
		else $error("frame not 140 slots");
	frame_time_a: assert property (fs && ok_ff |-> cyc_ff inside {[10'h2fd:10'h303]})
		else $error("frame period off rate");
	fs_single_a: assert property (fs |=> !fs [*8])
		else $error("frame start not single");
	overhead_zero_a: assert property (stb && !fs && ok_ff && VARIANT == VTM_BYTE_SYNC
		&& pos inside {8'h00, 8'h01, 8'h22} |-> container_data_out == 8'h00)
		else $error("overhead slot carries data");
	idle_quiet_a: assert property (idle_two |-> !stb && !fs && container_data_out == 8'h00)
		else $error("output active while inactive");
	enable_track_a: assert property ($changed(mgmt_activate) |=> container_output_enable == $past(mgmt_activate))
		else $error("enable does not follow");
	data_hold_a: assert property (!stb && mgmt_activate && $past(mgmt_activate) |-> $stable(container_data_out))
		else $error("data moved without strobe");
endmodule : vtm_mapper_props

bind vtm_mapper vtm_mapper_props #(.VARIANT(VARIANT)) u_vtm_mapper_props (
	.core_clk(core_clk), .rst(rst), .upstream_signal_fail_in(upstream_signal_fail_in),
	.mgmt_activate(mgmt_activate), .container_data_out(container_data_out),
	.container_clock_out(container_clock_out), .container_frame_start_out(container_frame_start_out),
	.container_output_enable(container_output_enable));

// ### tb/vtm_trib_src.sv
// Tributary source model: octet stream, frame start every 256 bits.
// Assumes clk is the tributary bit clock; data moves on its falling edge.
`timescale 1ns/1ps
module vtm_trib_src (
	input wire logic clk,
	input wire logic rst,
	output logic data,
	output logic fs
);
	logic [7:0] bit_ff = 8'h00;
	logic [3:0] wait_ff = 4'h0;
	wire logic [7:0] cur = {3'h5, bit_ff[7:3]};
	// Hold still after reset, then shift slot octets out
	always @(negedge clk) begin
		if (rst) begin
			wait_ff <= 4'h0;
			bit_ff <= 8'h00;
		end else if (wait_ff != 4'hf) begin
			wait_ff <= wait_ff + 4'h1;
		end else begin
			bit_ff <= bit_ff + 8'h01;
		end
	end
	// Most significant bit first
	assign data = (wait_ff == 4'hf) ? cur[~bit_ff[2:0]] : 1'b0;
	assign fs = (wait_ff == 4'hf) && (bit_ff == 8'h00);
endmodule : vtm_trib_src

// ### verilog/vtm_link_store.sv
// Dual clock store: packs tributary bits on the link clock, reads on core clock.
// Assumes fs_in marks the first bit of a word; gray pointers cross domains.
`timescale 1ns/1ps
module vtm_link_store import vtm_pkg::*; #(
	parameter int PACK = 8,
	parameter int AW = STORE_AW
) (
	input wire logic link_clk,
	input wire logic ser_in,
	input wire logic fs_in,
	input wire logic core_clk,
	input wire logic rst,
	input wire logic pop,
	output logic [PACK:0] head,
	output logic empty,
	output logic [AW:0] fill,
	output logic [AW:0] wr_seen
);

	localparam int DEPTH = 1 << AW;

	typedef struct packed {
		logic [PACK-1:0] shift;
		logic [3:0] bits;
		logic fs;
		logic [AW:0] wptr;
		logic [AW:0] wgray;
	} vtm_lnk_type;

	function automatic logic [AW:0] g2b(input logic [AW:0] g);
		logic [AW:0] b;
		b[AW] = g[AW];
		for (int i = AW - 1; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction : g2b

	logic [PACK:0] mem [DEPTH];
	vtm_lnk_type l_ff, nxt_l;
	logic [AW:0] rptr_ff, nxt_rptr;
	logic [AW:0] rgray_ff;
	logic [AW:0] rgray_l, wgray_c, rbin_l, wbin_c;
	logic lrst, wr_now, full;
	logic [PACK-1:0] word;

	vtm_sync2 #(.W(1)) u_rst (.clk(link_clk), .rst(1'b0), .d(rst), .q(lrst));
	vtm_sync2 #(.W(AW+1)) u_rg (.clk(link_clk), .rst(lrst), .d(rgray_ff), .q(rgray_l));
	vtm_sync2 #(.W(AW+1)) u_wg (.clk(core_clk), .rst(rst), .d(l_ff.wgray), .q(wgray_c));

	assign rbin_l = g2b(rgray_l);
	assign wbin_c = g2b(wgray_c);
	assign full = (AW+1)'(l_ff.wptr - rbin_l) == (AW+1)'(DEPTH);
	assign word = PACK'({l_ff.shift, ser_in});
	assign wr_now = (fs_in ? 4'h0 : l_ff.bits) == 4'(PACK - 1);

	// Link side packing; a frame start restarts word alignment
	always_comb begin
		nxt_l = l_ff;
		nxt_l.shift = word;
		nxt_l.bits = wr_now ? 4'h0 : 4'((fs_in ? 4'h0 : l_ff.bits) + 4'h1);
		nxt_l.fs = wr_now ? 1'b0 : (l_ff.fs | fs_in);
		if (wr_now && !full) begin
			nxt_l.wptr = l_ff.wptr + 1'b1;
			nxt_l.wgray = nxt_l.wptr ^ (nxt_l.wptr >> 1);
		end
	end

	always_ff @(posedge link_clk) begin
		if (lrst) begin
			l_ff <= '0;
		end else begin
			l_ff <= nxt_l;
		end
	end

	// Word storage, written on the link clock only
	always_ff @(posedge link_clk) begin
		if (wr_now && !full) begin
			mem[l_ff.wptr[AW-1:0]] <= {l_ff.fs | fs_in, word};
		end
	end

	// Core side read pointer
	always_comb begin
		nxt_rptr = (pop && !empty) ? rptr_ff + 1'b1 : rptr_ff;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rptr_ff <= '0;
			rgray_ff <= '0;
		end else begin
			rptr_ff <= nxt_rptr;
			rgray_ff <= nxt_rptr ^ (nxt_rptr >> 1);
		end
	end

	assign head = mem[rptr_ff[AW-1:0]];
	assign empty = wbin_c == rptr_ff;
	assign fill = wbin_c - rptr_ff;
	assign wr_seen = wbin_c;

endmodule : vtm_link_store

// ### verilog/vtm_mapper.sv
// Tributary to container mapper, source side, byte-sync or async variant.
// Assumes tributary pins are timed by tributary_clock_in; fail and timing pins are synchronised, all else core_clk.
`timescale 1ns/1ps
module vtm_mapper import vtm_pkg::*; #(
	parameter vtm_variant_type VARIANT = VTM_BYTE_SYNC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic tributary_clock_in,
	input wire logic tributary_data_in,
	input wire logic tributary_frame_start_in,
	input wire logic upstream_signal_fail_in,
	input wire logic mgmt_activate,
	input wire logic timing_clock_in,
	input wire logic timing_frame_start_in,
	output logic [7:0] container_data_out,
	output logic container_clock_out,
	output logic container_frame_start_out,
	output logic container_output_enable
);

	typedef struct packed {
		vtm_state_type st;
		logic [1:0] blk;
		logic [5:0] off;
		logic [7:0] credit;
		logic [STORE_AW:0] seen;
		logic [RES_W-1:0] res;
		logic [4:0] cnt;
		vtm_just_type just;
		logic ti_d;
		logic [7:0] data;
		logic stb;
		logic fs;
		logic oe;
	} vtm_core_type;

	vtm_core_type r_ff, nxt_r;
	logic [8:0] head;
	logic empty, pop;
	logic [STORE_AW:0] fill, wr_seen;
	logic fail, ti, tfs;

	// Pins from outside the core domain
	vtm_sync2 #(.W(3)) u_sync (
		.clk(core_clk),
		.rst(rst),
		.d({upstream_signal_fail_in, timing_clock_in, timing_frame_start_in}),
		.q({fail, ti, tfs})
	);

	generate
		if (VARIANT == VTM_BYTE_SYNC) begin : g_sync
			vtm_link_store #(.PACK(8), .AW(STORE_AW)) u_store (
				.link_clk(tributary_clock_in),
				.ser_in(tributary_data_in),
				.fs_in(tributary_frame_start_in),
				.core_clk(core_clk),
				.rst(rst),
				.pop(pop),
				.head(head),
				.empty(empty),
				.fill(fill),
				.wr_seen(wr_seen)
			);
		end else begin : g_async
			vtm_link_store #(.PACK(1), .AW(STORE_AW)) u_store (
				.link_clk(tributary_clock_in),
				.ser_in(tributary_data_in),
				.fs_in(1'b0),
				.core_clk(core_clk),
				.rst(rst),
				.pop(pop),
				.head(head[1:0]),
				.empty(empty),
				.fill(fill),
				.wr_seen(wr_seen)
			);
			assign head[8:2] = '0;
		end
	endgenerate

	// Slot sequencing, byte composition and justification
	always_comb begin
		logic slot;
		logic tsl;
		logic [1:0] b;
		logic [5:0] o;
		logic [7:0] d;
		logic [4:0] n;
		logic [RES_W-1:0] res;
		logic [4:0] cnt;
		logic [6:0] lvl;
		logic c1;
		logic c2;
		slot = 1'b0;
		tsl = 1'b0;
		b = r_ff.blk;
		o = r_ff.off;
		d = BYTE_ZERO;
		n = 5'h00;
		res = r_ff.res;
		cnt = r_ff.cnt;
		lvl = 7'(fill) + 7'(r_ff.cnt);
		c1 = r_ff.just != VTM_JUST_NEG;
		c2 = r_ff.just == VTM_JUST_POS;
		pop = 1'b0;
		nxt_r = r_ff;
		nxt_r.stb = 1'b0;
		nxt_r.fs = 1'b0;
		nxt_r.oe = mgmt_activate;
		nxt_r.ti_d = ti;
		if (VARIANT == VTM_BYTE_SYNC) begin
			nxt_r.seen = (r_ff.seen != wr_seen) ? r_ff.seen + 1'b1 : r_ff.seen;
			slot = r_ff.credit >= MUL_DEN;
			nxt_r.credit = 8'(r_ff.credit + ((r_ff.seen != wr_seen) ? MUL_NUM : 8'h00)
				- (slot ? MUL_DEN : 8'h00));
			if (r_ff.st == VTM_HUNT && !empty && !head[8]) begin
				pop = 1'b1;
			end
			if (slot) begin
				// realign on slot-zero word
				// Slack in the store lets extra slots hit data positions safely
				if (r_ff.st == VTM_HUNT && !empty && head[8] && fill >= LOCK_FILL) begin
					o = OFF_TS_FIRST;
					nxt_r.st = VTM_RUN;
				end
				tsl = o >= OFF_TS_FIRST && o <= OFF_TS_LAST;
				if (o == OFF_POH && b == 2'h0) begin
					d[LBL_LSB +: 3] = LBL_BYTE_SYNC;
				end else if (tsl) begin
					d = BYTE_ONES;
					if (nxt_r.st == VTM_RUN) begin
						if (empty || head[8] != (o == OFF_TS_FIRST)) begin
							nxt_r.st = VTM_HUNT;
						end else begin
							pop = 1'b1;
							d = fail ? BYTE_ONES : head[7:0];
						end
					end
				end
			end
		end else begin
			slot = ti && !r_ff.ti_d;
			if (slot) begin
				if (tfs) begin
					b = 2'h0;
					o = OFF_POH;
				end
				if (o == OFF_POH && b == 2'h0) begin
					d[LBL_LSB +: 3] = LBL_ASYNC;
				end else if (o == OFF_CTRL && b != 2'h0) begin
					d = {c1, c2, 6'h00};
					if (b == BLK_LAST && !c1) begin
						n = 5'h01;
						d[0] = r_ff.res[RES_W-1];
					end
				end else if (o >= OFF_TS_FIRST && o <= OFF_TS_LAST) begin
					n = 5'h08;
					d = r_ff.res[RES_W-1 -: 8];
					if (b == BLK_LAST && o == OFF_TS_FIRST && c2) begin
						n = 5'h07;
						d = {1'b0, r_ff.res[RES_W-1 -: 7]};
					end
				end
				if (o == OFF_CTRL && b == 2'h1) begin
					nxt_r.just = lvl < LVL_LOW ? VTM_JUST_POS :
						(lvl > LVL_HIGH ? VTM_JUST_NEG : VTM_JUST_NONE);
				end
			end
			res = r_ff.res << n;
			cnt = (r_ff.cnt >= n) ? 5'(r_ff.cnt - n) : 5'h00;
			// Refill the reservoir one bit per cycle
			if (cnt < RES_FULL && !empty) begin
				pop = 1'b1;
				res[4'(5'h0f - cnt)] = head[0];
				cnt = 5'(cnt + 5'h01);
			end
			nxt_r.res = res;
			nxt_r.cnt = cnt;
		end
		if (slot) begin
			nxt_r.stb = mgmt_activate;
			nxt_r.fs = mgmt_activate && o == OFF_POH && b == 2'h0;
			nxt_r.data = mgmt_activate ? d : BYTE_ZERO;
			if (o == OFF_LAST) begin
				nxt_r.off = OFF_POH;
				nxt_r.blk = 2'(b + 2'h1);
			end else begin
				nxt_r.off = 6'(o + 6'h01);
				nxt_r.blk = b;
			end
		end
		// no data left on the access point while inactive
		if (!mgmt_activate) begin
			nxt_r.data = BYTE_ZERO;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign container_data_out = r_ff.data;
	assign container_clock_out = r_ff.stb;
	assign container_frame_start_out = r_ff.fs;
	assign container_output_enable = r_ff.oe;

endmodule : vtm_mapper

// ### verilog/vtm_sync2.sv
// Two flip-flop level synchroniser, one per bit.
// Assumes each bit is a level that stays stable for several clocks.
`timescale 1ns/1ps
module vtm_sync2 import vtm_pkg::*; #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_ff <= '0;
			q_ff <= '0;
		end else begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end

	assign q = q_ff;

endmodule : vtm_sync2
